// ### shared/sat_params.svh
// constants for the smbus alert, timeout and general call block
`ifndef SAT_PARAMS_SVH
`define SAT_PARAMS_SVH
`define SAT_CLK_HZ 40000000
`define SAT_TIMEOUT_MIN_MS 25
`define SAT_TIMEOUT_MAX_MS 75
`define SAT_POR_TIME_US 500
`define SAT_TIMEOUT_CYC ((`SAT_CLK_HZ / 1000) * `SAT_TIMEOUT_MIN_MS + 1)
`define SAT_POR_CYC ((`SAT_CLK_HZ / 1000000) * `SAT_POR_TIME_US)
`define SAT_ARA_ADDR 7'h0c
`define SAT_GC_ADDR 7'h00
`define SAT_DEV_UPPER 4'h9
`define SAT_CMD_RELATCH 8'h04
`define SAT_CMD_RESET 8'h06
`define SAT_NV_WORDS 4
`define SAT_NV_AW 2
`define SAT_CNT_W 21
`endif

// ### shared/sat_pkg.sv
// types for the smbus alert, timeout and general call block
package sat_pkg;
  typedef enum logic [2:0] {
    SAT_IDLE, SAT_ADDR, SAT_ADDR_ACK, SAT_ARA_TX, SAT_ARA_WAIT, SAT_CMD, SAT_CMD_ACK, SAT_IGNORE
  } sat_state_e;
  typedef struct packed {
    logic sclIn;
    logic sdaIn;
  } sat_bus_in_s;
  typedef struct packed {
    logic sdaOut;
    logic sdaOe;
  } sat_bus_out_s;
  typedef struct packed {
    logic interruptMode;
    logic polarityHigh;
    logic alarmEvent;
    logic alarmUpper;
  } sat_alarm_s;
endpackage

// ### rtl/sat_nv_mem.sv
// small memory holding nonvolatile register words, registered read
`include "sat_params.svh"
module sat_nv_mem (
  // clock
  input wire logic sys_clk,
  // write side
  input wire logic wrEn,
  input wire logic [`SAT_NV_AW-1:0] wrAddr,
  input wire logic [15:0] wrData,
  // read side
  input wire logic [`SAT_NV_AW-1:0] rdAddr,
  output logic [15:0] rdData
);
  logic [15:0] mem [0:`SAT_NV_WORDS-1];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    rdData <= mem[rdAddr];
  end
endmodule

// ### rtl/sat_smbus_features.sv
// smbus alert response, bus timeout and general call slave logic
// What this block does
// - alert line serves smbus alert only in interrupt mode with active-low polarity
// - acknowledge alert response address only while our alert is asserted
// - after ack, send seven-bit address 1001 plus latched pins, msb first
// - eighth bit is one for upper limit, zero for lower limit
// - keep sending only while bus matches our bits; lowest address wins
// - winner releases alert once its whole address byte is sent
// - loser stops driving data and keeps alert asserted for later responses
// - clock low past minimum timeout resets serial state and releases data
// - new start is recognised well before maximum timeout after a timeout
// - general call address answered only with write bit zero
// - general call write byte is acknowledged, then a command byte awaited
// - command 04h re-samples address pins as new slave address
// - command 06h re-samples pins and copies nonvolatile into volatile registers
// - busy during general call reset lasts at most power-on reset time
`include "sat_params.svh"
module sat_smbus_features (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // two-wire bus
  input wire sat_pkg::sat_bus_in_s busIn,
  output sat_pkg::sat_bus_out_s busOut,
  // alarm source and configuration
  input wire sat_pkg::sat_alarm_s alarm,
  input wire logic [2:0] addressSelectPins,
  // alert pin, open drain
  output logic alertOut,
  output logic alertOe,
  // device state
  output logic [6:0] slaveAddr,
  output logic busy,
  output logic volatileLoad,
  output logic [1:0] volatileIdx,
  output logic [15:0] volatileData,
  output logic timeoutEvent,
  // nonvolatile write port
  input wire logic nvWrEn,
  input wire logic [1:0] nvWrAddr,
  input wire logic [15:0] nvWrData
);
  import sat_pkg::*;

  logic rstSync1_reg, rstN;
  sat_state_e state_reg, state_next;
  logic sclD_reg, sdaD_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] txByte_reg;
  logic sdaDrive_reg;
  logic [`SAT_CNT_W-1:0] lowCnt_reg;
  logic alertPend_reg, alertUpper_reg;
  logic [2:0] pins_reg;
  logic [18:0] busyCnt_reg;
  logic copyAct_reg;
  logic [1:0] copyIdx_reg;
  logic copyRdValid_reg;
  logic [1:0] copyWrIdx_reg;
  logic [15:0] nvRdData;
  logic sclRise, sclFall, startCond, stopCond, timeout, smbusAlertMode;
  logic relatch, gcReset;

  // reset released through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1_reg <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstN <= rstSync1_reg;
    end
  end

  function automatic logic edgeOf(input logic prev, input logic cur, input logic rise);
    edgeOf = rise ? (!prev && cur) : (prev && !cur);
  endfunction

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      sclD_reg <= 1'b1;
      sdaD_reg <= 1'b1;
    end else begin
      sclD_reg <= busIn.sclIn;
      sdaD_reg <= busIn.sdaIn;
    end
  end

  assign sclRise = edgeOf(sclD_reg, busIn.sclIn, 1'b1);
  assign sclFall = edgeOf(sclD_reg, busIn.sclIn, 1'b0);
  // start/stop: data moves while clock high
  assign startCond = busIn.sclIn && sclD_reg && edgeOf(sdaD_reg, busIn.sdaIn, 1'b0);
  assign stopCond = busIn.sclIn && sclD_reg && edgeOf(sdaD_reg, busIn.sdaIn, 1'b1);

  // clock low counter, restarted on every rise
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      lowCnt_reg <= '0;
    end else if (busIn.sclIn) begin
      lowCnt_reg <= '0;
    end else if (lowCnt_reg != `SAT_CNT_W'(`SAT_TIMEOUT_CYC)) begin
      lowCnt_reg <= lowCnt_reg + 1'b1;
    end
  end
  // one-shot pulse; state is idle the next cycle, so a start is seen at once
  assign timeout = (lowCnt_reg == `SAT_CNT_W'(`SAT_TIMEOUT_CYC - 1)) && !busIn.sclIn;
  assign timeoutEvent = timeout;

  assign smbusAlertMode = alarm.interruptMode && !alarm.polarityHigh;

  // protocol state
  always_comb begin
    state_next = state_reg;
    if (sclFall) begin
      case (state_reg)
        SAT_ADDR: begin
          if (bitCnt_reg == 4'h8) begin
            if (shift_reg == {`SAT_ARA_ADDR, 1'b1} && alertPend_reg && smbusAlertMode) begin
              state_next = SAT_ADDR_ACK;
            end else if (shift_reg == {`SAT_GC_ADDR, 1'b0}) begin
              state_next = SAT_ADDR_ACK;
            end else begin
              state_next = SAT_IGNORE;
            end
          end
        end
        SAT_ADDR_ACK: state_next = shift_reg[0] ? SAT_ARA_TX : SAT_CMD;
        SAT_ARA_TX: begin
          if (bitCnt_reg == 4'h8) begin
            state_next = SAT_ARA_WAIT;
          end
        end
        SAT_ARA_WAIT: state_next = SAT_IGNORE;
        SAT_CMD: begin
          if (bitCnt_reg == 4'h8) begin
            state_next = SAT_CMD_ACK;
          end
        end
        SAT_CMD_ACK: state_next = SAT_IGNORE;
        default: state_next = state_reg;
      endcase
    end
    // lost arbitration: bus low while we release it
    if (state_reg == SAT_ARA_TX && sclRise && sdaDrive_reg == 1'b0 && !busIn.sdaIn && txByte_reg[7]) begin
      state_next = SAT_IGNORE;
    end
    if (startCond) begin
      state_next = SAT_ADDR;
    end
    if (stopCond || timeout) begin
      state_next = SAT_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= SAT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // bit counter and receive shifter
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      bitCnt_reg <= '0;
      shift_reg <= '0;
    end else if (startCond || state_next != state_reg) begin
      bitCnt_reg <= '0;
    end else if (sclRise && (state_reg == SAT_ADDR || state_reg == SAT_CMD || state_reg == SAT_ARA_TX)) begin
      bitCnt_reg <= bitCnt_reg + 1'b1;
      shift_reg <= {shift_reg[6:0], busIn.sdaIn};
    end
  end

  // transmit byte: address then limit bit, msb first
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      txByte_reg <= '0;
    end else if (state_reg == SAT_ADDR_ACK && state_next == SAT_ARA_TX) begin
      txByte_reg <= {slaveAddr, alertUpper_reg};
    end else if (state_reg == SAT_ARA_TX && sclFall) begin
      txByte_reg <= {txByte_reg[6:0], 1'b0};
    end
  end

  // data line drive; low only, open drain
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      sdaDrive_reg <= 1'b0;
    end else if (timeout || stopCond || startCond) begin
      sdaDrive_reg <= 1'b0;
    end else if (sclFall) begin
      case (state_next)
        SAT_ADDR_ACK: sdaDrive_reg <= 1'b1;
        SAT_CMD_ACK: sdaDrive_reg <= 1'b1;
        SAT_ARA_TX: sdaDrive_reg <= (state_reg == SAT_ADDR_ACK) ? !slaveAddr[6] : !txByte_reg[6];
        default: sdaDrive_reg <= 1'b0;
      endcase
    end else if (state_next == SAT_IGNORE) begin
      sdaDrive_reg <= 1'b0;
    end
  end
  assign busOut.sdaOut = 1'b0;
  assign busOut.sdaOe = sdaDrive_reg;

  // alert latch; new alarm wins over clear
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      alertPend_reg <= 1'b0;
      alertUpper_reg <= 1'b0;
    end else if (alarm.alarmEvent) begin
      alertPend_reg <= 1'b1;
      alertUpper_reg <= alarm.alarmUpper;
    end else if (state_reg == SAT_ARA_TX && state_next == SAT_ARA_WAIT) begin
      alertPend_reg <= 1'b0;
    end
  end
  // the alert pin is owned here only in smbus alert mode
  assign alertOe = alertPend_reg && smbusAlertMode;
  assign alertOut = 1'b0;

  // general call commands
  assign relatch = state_reg == SAT_CMD && sclFall && bitCnt_reg == 4'h8 &&
                   (shift_reg == `SAT_CMD_RELATCH || shift_reg == `SAT_CMD_RESET);
  assign gcReset = relatch && shift_reg == `SAT_CMD_RESET;

  // pins caught after reset release, then on command
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pins_reg <= '0;
    end else if (busyCnt_reg == 19'h00001 || relatch) begin
      pins_reg <= addressSelectPins;
    end
  end
  assign slaveAddr = {`SAT_DEV_UPPER, pins_reg};

  // busy window bounded by power-on reset time
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      busyCnt_reg <= 19'h00002;
    end else if (gcReset) begin
      busyCnt_reg <= 19'(`SAT_POR_CYC);
    end else if (busyCnt_reg != '0) begin
      busyCnt_reg <= busyCnt_reg - 1'b1;
    end
  end
  assign busy = busyCnt_reg != '0;

  // copy nonvolatile words into volatile registers
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      copyAct_reg <= 1'b0;
      copyIdx_reg <= '0;
      copyRdValid_reg <= 1'b0;
      copyWrIdx_reg <= '0;
    end else begin
      copyRdValid_reg <= copyAct_reg;
      copyWrIdx_reg <= copyIdx_reg;
      if (gcReset) begin
        copyAct_reg <= 1'b1;
        copyIdx_reg <= '0;
      end else if (copyAct_reg) begin
        copyIdx_reg <= copyIdx_reg + 1'b1;
        if (copyIdx_reg == 2'(`SAT_NV_WORDS - 1)) begin
          copyAct_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      volatileLoad <= 1'b0;
      volatileIdx <= '0;
      volatileData <= '0;
    end else begin
      volatileLoad <= copyRdValid_reg;
      volatileIdx <= copyWrIdx_reg;
      volatileData <= nvRdData;
    end
  end

  // nonvolatile words; read registered so a word lags its index by one cycle
  sat_nv_mem nvMem (
    .sys_clk(sys_clk),
    .wrEn(nvWrEn),
    .wrAddr(nvWrAddr),
    .wrData(nvWrData),
    .rdAddr(copyIdx_reg),
    .rdData(nvRdData)
  );
endmodule

// ### verif/sat_smbus_features_props.sv
// assertions on the ports of the smbus features block
`include "sat_params.svh"
module sat_smbus_features_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // watched ports
  input wire sat_pkg::sat_bus_in_s busIn,
  input wire sat_pkg::sat_bus_out_s busOut,
  input wire sat_pkg::sat_alarm_s alarm,
  input wire logic alertOe,
  input wire logic [6:0] slaveAddr,
  input wire logic [2:0] addressSelectPins,
  input wire logic busy,
  input wire logic volatileLoad,
  input wire logic timeoutEvent
);
  import sat_pkg::*;
  logic [20:0] lowCnt_reg;
  logic [15:0] busyCnt_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // clock low age, restarts on any high sample
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      lowCnt_reg <= '0;
    else
      lowCnt_reg <= busIn.sclIn ? '0 : lowCnt_reg + 21'h1;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      busyCnt_reg <= '0;
    else
      busyCnt_reg <= busy ? busyCnt_reg + 16'h1 : '0;
  end
  AST_ALERT_MODE: assert property (alertOe |-> alarm.interruptMode && !alarm.polarityHigh)
    else $error("alert driven outside smbus alert mode");
  AST_ALERT_SET: assert property (alarm.alarmEvent && alarm.interruptMode && !alarm.polarityHigh |=> alertOe)
    else $error("alarm did not raise alert");
  AST_SDA_ON_LOW: assert property ($rose(busOut.sdaOe) |-> !busIn.sclIn)
    else $error("data pulled while clock high");
  AST_TIMEOUT_AGE: assert property (timeoutEvent |-> lowCnt_reg >= `SAT_TIMEOUT_CYC - 10)
    else $error("timeout before minimum interval");
  AST_TIMEOUT_FREE: assert property (timeoutEvent |=> !busOut.sdaOe)
    else $error("data held after timeout");
  AST_BUSY_BOUND: assert property (busyCnt_reg <= `SAT_POR_CYC)
    else $error("busy longer than reset time");
  AST_ADDR_UPPER: assert property ($changed(slaveAddr) |-> slaveAddr == {`SAT_DEV_UPPER, $past(addressSelectPins)})
    else $error("slave address not taken from pins");
  AST_LOAD_BURST: assert property ($rose(volatileLoad) |-> volatileLoad[*4] ##1 !volatileLoad)
    else $error("copy burst not four words");
  AST_LOAD_BUSY: assert property (volatileLoad |-> busy)
    else $error("copy while not busy");
endmodule
bind sat_smbus_features sat_smbus_features_props i_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .busIn(busIn), .busOut(busOut), .alarm(alarm), .alertOe(alertOe), .slaveAddr(slaveAddr),
  .addressSelectPins(addressSelectPins),
  .busy(busy), .volatileLoad(volatileLoad), .timeoutEvent(timeoutEvent));

// ### verif/sat_smbus_master.sv
// smbus master model plus a second alerting slave on data
module sat_smbus_master (
  // clock
  input wire logic sys_clk,
  // device pull on data
  input wire logic devOe,
  input wire logic devOut,
  // bus levels seen by the device
  output sat_pkg::sat_bus_in_s bus
);
  timeunit 1ns;
  timeprecision 1ps;
  import sat_pkg::*;
  logic scl = 1'b1;
  logic sdaM = 1'b1;
  logic [7:0] rival = 8'hff;
  int bitIdx = -1;
  // pull-ups: low only while some party pulls
  assign bus.sclIn = scl;
  assign bus.sdaIn = sdaM & (devOe ? devOut : 1'b1) & ~(bitIdx >= 0 && !rival[bitIdx[2:0]]);
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic start();
    tick(8);
    sdaM = 1'b0;
    tick(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sdaM = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(8);
    sdaM = 1'b1;
    tick(8);
  endtask
  // short phases, still far below the timeout floor
  task automatic xfer(input logic b, output logic got);
    tick(2);
    sdaM = b;
    tick(6);
    scl = 1'b1;
    tick(8);
    got = bus.sdaIn;
    scl = 1'b0;
  endtask
  // rival slave sends its bits only during reads
  task automatic byteX(input logic [7:0] tx, input logic rd, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitIdx = rd ? i : -1;
      xfer(tx[i], rx[i]);
    end
    bitIdx = -1;
    xfer(1'b1, ack);
  endtask
endmodule

// ### verif/tb_sat_smbus_features.sv
// self-checking bench for the smbus features block
`include "sat_params.svh"
module tb_sat_smbus_features;
  timeunit 1ns;
  timeprecision 1ps;
  import sat_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  sat_bus_in_s busIn;
  sat_bus_out_s busOut;
  sat_alarm_s alarm = '0;
  logic [2:0] pins = 3'h5;
  logic alertOe, busy, vLoad;
  logic nvWrEn = 1'b0;
  logic [6:0] slaveAddr;
  logic [1:0] vIdx;
  logic [1:0] nvWrAddr = '0;
  logic [15:0] vData;
  logic [15:0] nvWrData = '0;
  logic [15:0] nvWords [4];
  logic [7:0] rx;
  logic ack;
  logic alertLvl, toEv;
  logic toSeen = 1'b0;
  int fails = 0;
  int tests_run = 0;
  int loads = 0;
  sat_smbus_features i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .busIn(busIn), .busOut(busOut),
    .alarm(alarm), .addressSelectPins(pins), .alertOut(alertLvl), .alertOe(alertOe), .slaveAddr(slaveAddr),
    .busy(busy), .volatileLoad(vLoad), .volatileIdx(vIdx), .volatileData(vData), .timeoutEvent(toEv),
    .nvWrEn(nvWrEn), .nvWrAddr(nvWrAddr), .nvWrData(nvWrData));
  sat_smbus_master i_mst (.sys_clk(sys_clk), .devOe(busOut.sdaOe), .devOut(busOut.sdaOut), .bus(busIn));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // sticky: any timeout pulse during ordinary traffic is a fault
  always @(negedge sys_clk) begin
    if (reset_n === 1'b1 && toEv !== 1'b0) begin
      toSeen = 1'b1;
    end
  end
  // sampled mid-cycle, away from the edge that launches the word
  always @(negedge sys_clk) begin
    if (vLoad === 1'b1) begin
      loads++;
      check(vData, nvWords[vIdx], "copied word");
    end
  end
  task automatic raise(input logic up);
    alarm.alarmUpper = up;
    alarm.alarmEvent = 1'b1;
    i_mst.tick(1);
    alarm.alarmEvent = 1'b0;
  endtask
  task automatic ara(input logic expAck, input logic [7:0] expRx);
    i_mst.start();
    i_mst.byteX(8'h19, 1'b0, rx, ack);
    check(16'(ack), 16'(expAck), "ara ack");
    if (!expAck)
      i_mst.byteX(8'hff, 1'b1, rx, ack);
    if (!expAck)
      check(16'(rx), 16'(expRx), "ara address");
    i_mst.stop();
  endtask
  task automatic gc(input logic [7:0] cmd);
    i_mst.start();
    i_mst.byteX(8'h00, 1'b0, rx, ack);
    check(16'(ack), 16'h0, "gc ack");
    i_mst.byteX(cmd, 1'b0, rx, ack);
    check(16'(ack), 16'h0, "command ack");
    i_mst.stop();
  endtask
  task automatic test_alert();
    alarm.interruptMode = 1'b1;
    raise(1'b1);
    check(16'(alertOe), 16'h1, "alert set");
    check(16'(alertLvl), 16'h0, "alert pin pulls low");
    ara(1'b0, 8'h9b);
    check(16'(alertOe), 16'h0, "alert cleared");
    alarm.polarityHigh = 1'b1;
    raise(1'b0);
    check(16'(alertOe), 16'h0, "alert off when active high");
    ara(1'b1, 8'h00);
    alarm.polarityHigh = 1'b0;
    i_mst.rival = 8'h93;
    ara(1'b0, 8'h93);
    check(16'(alertOe), 16'h1, "loser keeps alert");
    i_mst.rival = 8'hff;
    ara(1'b0, 8'h9a);
    check(16'(alertOe), 16'h0, "second response clears");
    $display("test alert done");
  endtask
  task automatic test_gc();
    i_mst.start();
    i_mst.byteX(8'h01, 1'b0, rx, ack);
    check(16'(ack), 16'h1, "gc read refused");
    i_mst.stop();
    pins = 3'h2;
    gc(8'h04);
    check(16'(slaveAddr), 16'h4a, "relatch");
    for (int i = 0; i < 4; i++) begin
      nvWords[i] = 16'ha5c0 + 16'(i);
      nvWrAddr = 2'(i);
      nvWrData = nvWords[i];
      nvWrEn = 1'b1;
      i_mst.tick(1);
    end
    nvWrEn = 1'b0;
    pins = 3'h6;
    loads = 0;
    gc(8'h06);
    for (int n = 0; n <= `SAT_POR_CYC && busy; n++)
      i_mst.tick(1);
    check(16'(busy), 16'h0, "busy within reset time");
    check(16'(loads), 16'h4, "words copied");
    check(16'(slaveAddr), 16'h4e, "reset relatch");
    check(16'(toSeen), 16'h0, "no timeout at normal clock rate");
    $display("test gc done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    i_mst.tick(6);
    test_alert();
    test_gc();
    test_done();
  end
  // generous bound over both tests
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    test_done();
  end
endmodule
